// ---- design/eprom_prog_consts.vh ----
// timing, limit and encoding constants for the eprom programmer
`ifndef EPROM_PROG_CONSTS_VH
`define EPROM_PROG_CONSTS_VH

// clock
`define CLK_PERIOD_NS      20

// read timing, slowest speed grade
`define T_ACCESS_NS        300
`define T_GATE_NS          120
`define SYNC_STAGES        2

// program and margin timing
`define T_SETUP_US         2
`define T_HOLD_US          2
`define T_SUPPLY_US        50
`define T_MARGIN_OP_US     2
`define INIT_PULSE_US      1000
`define MARGIN_PULSE_US    500

// derived cycle counts (least times rounded up, pulse widths truncated)
`define ACCESS_CYC   ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_STAGES)
`define SETUP_CYC    ((`T_SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC     ((`T_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUPPLY_CYC   ((`T_SUPPLY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOP_CYC      ((`T_MARGIN_OP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_PULSE_CYC   ((`INIT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define MARGIN_PULSE_CYC ((`MARGIN_PULSE_US * 1000) / `CLK_PERIOD_NS)

// algorithm limits
`define MAX_PULSES         5'h19
`define OVP_FACTOR         3
`define MARGIN_BIT         10

// commands
`define OP_READ            2'h0
`define OP_FAST            2'h1
`define OP_MARGIN          2'h2

// phases
`define PH_READ            2'h0
`define PH_PROG            2'h1
`define PH_CHECK           2'h2

// widths
`define TMR_W              24

`endif

// ---- design/eprom_prog_host.v ----
// host controller that reads and programs a 64K x 8 uv eprom through its pins
//
// How it works
// RULE_01: device drives data only with select and gate low
// RULE_02: gate pin only enables outputs; select sets power
// RULE_03: data valid after access delay; we wait that
// RULE_04: select high puts device in standby, outputs float
// RULE_05: select from decode, gate from read strobe
// RULE_06: erased bits read one; programming only clears
// RULE_07: program mode: gate at vpp, select low, byte
// RULE_08: fast: 1 ms pulses, verify each, max 25
// RULE_09: fast: overprogram pulse lasts 3 ms times count
// RULE_10: pulses with vpp on gate; verify with gate low
// RULE_11: fast end: read all bytes at 5 V, compare
// RULE_12: margin: set mode, n zero, 500 us pulses
// RULE_13: margin sequence applies no overprogram pulses
// RULE_14: margin: count failed verifies, fail at 25
// RULE_15: margin end: reset mode, read all, report; a run failing at 25 pulses stops without the reset pulse
// RULE_16: margin line high sets, low clears flip-flop
// RULE_17: supply drop clears margin mode; treat as lost
// RULE_18: select high with vpp present inhibits programming
// RULE_19: fast: byte failing after 25 pulses stops run
`timescale 1ns/100ps
`default_nettype none
`include "eprom_prog_consts.vh"

module eprom_prog_host #(
  parameter INIT_PULSE_CYC   = `INIT_PULSE_CYC,
  parameter MARGIN_PULSE_CYC = `MARGIN_PULSE_CYC,
  parameter SUPPLY_CYC       = `SUPPLY_CYC
) (
  input  wire        CORE_CLK,
  input  wire        SYS_RST,
  input  wire        CMD_GO,
  input  wire [1:0]  CMD_OP,
  input  wire [15:0] CMD_FIRST,
  input  wire [15:0] CMD_LAST,
  output wire        BUSY,
  output wire        DONE,
  output wire        PASS,
  output wire [15:0] FAIL_ADDR,
  output wire [7:0]  RD_DATA,
  output wire        SRC_REQ,
  output wire [15:0] SRC_ADDR,
  input  wire [7:0]  SRC_DATA,
  input  wire        SRC_ACK,
  input  wire        PWR_LOW,
  output wire [15:0] EP_ADDR,
  output wire        EP_CE_N,
  output wire        EP_OE_N,
  output wire        EP_VPP_ON,
  output wire        EP_VCC_PROG,
  input  wire [7:0]  EP_DQ_IN,
  output wire [7:0]  EP_DQ_OUT,
  output wire        EP_DQ_OE
);

  // sequencer states
  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_PWR    = 4'h1;
  localparam [3:0] S_MSET   = 4'h2;
  localparam [3:0] S_MPULSE = 4'h3;
  localparam [3:0] S_MHOLD  = 4'h4;
  localparam [3:0] S_FETCH  = 4'h5;
  localparam [3:0] S_PSETUP = 4'h6;
  localparam [3:0] S_PULSE  = 4'h7;
  localparam [3:0] S_PHOLD  = 4'h8;
  localparam [3:0] S_RSETUP = 4'h9;
  localparam [3:0] S_RCHECK = 4'hA;

  reg  [3:0]        state_q;
  reg  [1:0]        op_q;
  reg  [1:0]        ph_q;
  reg  [15:0]       addr_q;
  reg  [15:0]       first_q;
  reg  [15:0]       last_q;
  reg  [7:0]        data_q;
  reg  [7:0]        rd_q;
  reg  [4:0]        n_q;
  reg               ovp_q;
  reg               mval_q;
  reg               margin_on_q;
  reg               busy_q;
  reg               done_q;
  reg               pass_q;
  reg  [15:0]       fail_addr_q;
  reg               ce_n_q;
  reg               oe_n_q;
  reg               vpp_q;
  reg               vcc_prog_q;
  reg  [7:0]        dq_out_q;
  reg               dq_oe_q;
  reg               tload_q;
  reg  [`TMR_W-1:0] tval_q;
  wire              tdone;
  wire [8:0]        sync_out;
  wire [7:0]        dq_s;
  wire              pwr_low_s;

  // cut a cycle count to the timer width
  function [`TMR_W-1:0] cyc;
    input integer n;
    reg   [31:0]  v;
    begin
      v = n;
      cyc = v[`TMR_W-1:0];
    end
  endfunction

  // overprogram pulse length: factor times initial pulses times 1 ms
  function [`TMR_W-1:0] ovp_len;
    input [4:0]   x;
    input integer unit;
    reg   [31:0]  v;
    begin
      v = `OVP_FACTOR * {27'h0, x} * unit;
      ovp_len = v[`TMR_W-1:0];
    end
  endfunction

  // pin inputs pass two flops before use
  pin_sync #(
    .W (9)
  ) u_sync (
    .clk  (CORE_CLK),
    .rst  (SYS_RST),
    .din  ({PWR_LOW, EP_DQ_IN}),
    .dout (sync_out)
  );

  assign dq_s      = sync_out[7:0];
  assign pwr_low_s = sync_out[8];

  wait_timer u_tmr (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .load  (tload_q),
    .value (tval_q),
    .done  (tdone)
  );

  // end of a run: drop every control pin back to standby
  task finish;
    input ok;
    begin
      state_q     <= S_IDLE;
      busy_q      <= 1'b0;
      done_q      <= 1'b1;
      pass_q      <= ok;
      ce_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
      vpp_q       <= 1'b0;
      vcc_prog_q  <= 1'b0;
      dq_oe_q     <= 1'b0;
      margin_on_q <= 1'b0;
      if (!ok) begin
        fail_addr_q <= addr_q;
      end
    end
  endtask

  // start a wait of the given length
  task start;
    input [`TMR_W-1:0] len;
    begin
      tload_q <= 1'b1;
      tval_q  <= len;
    end
  endtask

  // drive the byte and raise vpp before a program pulse
  task prog_setup;
    begin
      state_q  <= S_PSETUP;
      dq_out_q <= data_q;
      dq_oe_q  <= 1'b1;
      oe_n_q   <= 1'b1;
      vpp_q    <= 1'b1;
      start(cyc(`SETUP_CYC));
    end
  endtask

  // advance to next byte or close the programming or checking pass
  task next_addr;
    begin
      if (addr_q != last_q) begin
        addr_q  <= addr_q + 16'h0001;
        state_q <= S_FETCH;
      end else if (ph_q == `PH_CHECK) begin
        finish(1'b1);
      end else if (op_q == `OP_MARGIN) begin
        mval_q                <= 1'b0;
        addr_q[`MARGIN_BIT]   <= 1'b0; // [RULE_15] [RULE_16]
        vpp_q                 <= 1'b1;
        state_q               <= S_MSET;
        start(cyc(`SETUP_CYC));
      end else begin
        vcc_prog_q <= 1'b0; // [RULE_11]
        ph_q       <= `PH_CHECK;
        state_q    <= S_PWR;
        start(cyc(SUPPLY_CYC));
      end
    end
  endtask

  // main sequencer
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q     <= S_IDLE;
      op_q        <= `OP_READ;
      ph_q        <= `PH_READ;
      addr_q      <= 16'h0000;
      first_q     <= 16'h0000;
      last_q      <= 16'h0000;
      data_q      <= 8'hFF;
      rd_q        <= 8'h00;
      n_q         <= 5'h00;
      ovp_q       <= 1'b0;
      mval_q      <= 1'b0;
      margin_on_q <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      pass_q      <= 1'b0;
      fail_addr_q <= 16'h0000;
      ce_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
      vpp_q       <= 1'b0;
      vcc_prog_q  <= 1'b0;
      dq_out_q    <= 8'h00;
      dq_oe_q     <= 1'b0;
      tload_q     <= 1'b0;
      tval_q      <= {`TMR_W{1'b0}};
    end else begin
      tload_q <= 1'b0;
      done_q  <= 1'b0;
      if (margin_on_q && pwr_low_s) begin
        finish(1'b0); // [RULE_17]
      end else begin
        case (state_q)
          S_IDLE: begin
            if (CMD_GO) begin
              op_q    <= CMD_OP;
              addr_q  <= CMD_FIRST;
              first_q <= CMD_FIRST;
              last_q  <= CMD_LAST;
              busy_q  <= 1'b1;
              pass_q  <= 1'b0;
              if (CMD_OP == `OP_READ) begin
                ph_q    <= `PH_READ;
                ce_n_q  <= 1'b0; // [RULE_01] [RULE_05]
                oe_n_q  <= 1'b0; // [RULE_02]
                state_q <= S_RSETUP;
                start(cyc(`ACCESS_CYC));
              end else begin
                ph_q       <= `PH_PROG;
                vcc_prog_q <= 1'b1;
                state_q    <= S_PWR;
                start(cyc(SUPPLY_CYC));
              end
            end
          end
          S_PWR: begin
            if (tdone) begin
              if (ph_q == `PH_PROG && op_q == `OP_MARGIN) begin
                mval_q              <= 1'b1;
                addr_q[`MARGIN_BIT] <= 1'b1; // [RULE_12] [RULE_16]
                vpp_q               <= 1'b1;
                state_q             <= S_MSET;
                start(cyc(`SETUP_CYC));
              end else begin
                addr_q  <= first_q;
                state_q <= S_FETCH;
              end
            end
          end
          S_MSET: begin
            if (tdone) begin
              ce_n_q  <= 1'b0;
              state_q <= S_MPULSE;
              start(cyc(`MOP_CYC));
            end
          end
          S_MPULSE: begin
            if (tdone) begin
              ce_n_q  <= 1'b1;
              state_q <= S_MHOLD;
              start(cyc(`HOLD_CYC));
            end
          end
          S_MHOLD: begin
            if (tdone) begin
              vpp_q       <= 1'b0;
              margin_on_q <= mval_q;
              addr_q      <= first_q;
              if (mval_q) begin
                state_q <= S_FETCH;
              end else begin
                vcc_prog_q <= 1'b0;
                ph_q       <= `PH_CHECK;
                state_q    <= S_PWR;
                start(cyc(SUPPLY_CYC));
              end
            end
          end
          S_FETCH: begin
            if (SRC_ACK) begin
              data_q <= SRC_DATA;
              n_q    <= 5'h00; // [RULE_12]
              ovp_q  <= 1'b0;
              if (ph_q == `PH_PROG) begin
                state_q  <= S_PSETUP;
                dq_out_q <= SRC_DATA;
                dq_oe_q  <= 1'b1; // [RULE_07]
                oe_n_q   <= 1'b1;
                vpp_q    <= 1'b1; // [RULE_10]
                start(cyc(`SETUP_CYC));
              end else begin
                ce_n_q  <= 1'b0;
                oe_n_q  <= 1'b0;
                state_q <= S_RSETUP;
                start(cyc(`ACCESS_CYC));
              end
            end
          end
          S_PSETUP: begin
            if (tdone) begin
              ce_n_q  <= 1'b0; // [RULE_07] [RULE_18]
              state_q <= S_PULSE;
              if (ovp_q) begin
                start(ovp_len(n_q, INIT_PULSE_CYC)); // [RULE_09]
              end else if (op_q == `OP_MARGIN) begin
                start(cyc(MARGIN_PULSE_CYC)); // [RULE_12]
              end else begin
                start(cyc(INIT_PULSE_CYC)); // [RULE_08]
              end
            end
          end
          S_PULSE: begin
            if (tdone) begin
              ce_n_q  <= 1'b1;
              state_q <= S_PHOLD;
              start(cyc(`HOLD_CYC));
            end
          end
          S_PHOLD: begin
            if (tdone) begin
              vpp_q   <= 1'b0;
              dq_oe_q <= 1'b0;
              if (ovp_q) begin
                next_addr;
              end else begin
                n_q     <= n_q + 5'h01; // [RULE_14]
                ce_n_q  <= 1'b0;
                oe_n_q  <= 1'b0; // [RULE_10]
                state_q <= S_RSETUP;
                start(cyc(`ACCESS_CYC));
              end
            end
          end
          S_RSETUP: begin
            if (tdone) begin
              rd_q    <= dq_s; // [RULE_03]
              ce_n_q  <= 1'b1; // [RULE_04]
              oe_n_q  <= 1'b1;
              state_q <= S_RCHECK;
            end
          end
          S_RCHECK: begin
            if (ph_q == `PH_READ) begin
              finish(1'b1);
            end else if (ph_q == `PH_CHECK) begin
              if (rd_q != data_q) begin
                finish(1'b0); // [RULE_11] [RULE_15]
              end else begin
                next_addr;
              end
            end else if (rd_q == data_q) begin // [RULE_06]
              if (op_q == `OP_FAST) begin
                ovp_q <= 1'b1; // [RULE_09]
                prog_setup;
              end else begin
                next_addr; // [RULE_13]
              end
            end else if (n_q == `MAX_PULSES) begin
              finish(1'b0); // [RULE_14] [RULE_19]
            end else begin
              prog_setup; // [RULE_08]
            end
          end
          default: begin
            finish(1'b0);
          end
        endcase
      end
    end
  end

  // user side
  assign BUSY      = busy_q;
  assign DONE      = done_q;
  assign PASS      = pass_q;
  assign FAIL_ADDR = fail_addr_q;
  assign RD_DATA   = rd_q;
  assign SRC_REQ   = (state_q == S_FETCH);
  assign SRC_ADDR  = addr_q;

  // device pins
  assign EP_ADDR     = addr_q;
  assign EP_CE_N     = ce_n_q;
  assign EP_OE_N     = oe_n_q;
  assign EP_VPP_ON   = vpp_q;
  assign EP_VCC_PROG = vcc_prog_q;
  assign EP_DQ_OUT   = dq_out_q;
  assign EP_DQ_OE    = dq_oe_q;

endmodule // eprom_prog_host
`default_nettype wire

// ---- design/pin_sync.v ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // pin_sync
`default_nettype wire

// ---- design/wait_timer.v ----
// down-counting wait timer used for every pin delay and pulse width
`timescale 1ns/100ps
`default_nettype none
`include "eprom_prog_consts.vh"

module wait_timer (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 load,
  input  wire [`TMR_W-1:0]    value,
  output wire                 done
);

  reg [`TMR_W-1:0] cnt_q;

  // load then count down to zero
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {`TMR_W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {`TMR_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(`TMR_W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_q == {`TMR_W{1'b0}}) & ~load;

endmodule // wait_timer
`default_nettype wire

// ---- verif/eprom_model.sv ----
// behavioural model of the 64K x 8 uv eprom facing the host
`timescale 1ns/100ps
`default_nettype none
module eprom_model (
  input wire logic        clk,
  input wire logic [15:0] addr,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        vpp_on,
  input wire logic        pwr_low,
  input wire logic [7:0]  host_dq,
  input wire logic        host_oe,
  output var logic [7:0]  dq
);
  localparam int ACC_CYC = 15; // 300 ns at a 20 ns clock
  logic [7:0] mem [0:65535];
  int         need [0:65535];
  int         cnt [0:65535];
  int         op_len [0:65535];
  int         len_q;
  int         acc_q;
  logic       margin_q;
  logic       margin_seen;
  logic       ce_n_q;
  logic [7:0] last_q;
  // erased array, one pulse per byte unless a test asks for more
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
      need[i] = 1;
      cnt[i] = 0;
    end
    len_q = 0;
    acc_q = 0;
    margin_q = 1'b0;
    margin_seen = 1'b0;
    ce_n_q = 1'b1;
    last_q = 8'hFF;
  end
  // data pins: device data late after access, else the host, else a changing pattern
  always_comb begin
    if (!ce_n && !oe_n && !vpp_on) dq = (acc_q >= ACC_CYC) ? mem[addr] : ~last_q;
    else if (host_oe) dq = host_dq;
    else dq = ~last_q;
  end
  // pulses act at the rising select edge; select high never programs
  always @(posedge clk) begin
    last_q <= dq;
    ce_n_q <= ce_n;
    acc_q <= (!ce_n && !oe_n && !vpp_on) ? acc_q + 1 : 0;
    len_q <= (!ce_n && vpp_on) ? len_q + 1 : 0;
    if (ce_n && !ce_n_q && vpp_on && host_oe) begin
      cnt[addr] <= cnt[addr] + 1;
      op_len[addr] <= len_q;
      if (cnt[addr] + 1 >= need[addr]) mem[addr] <= mem[addr] & host_dq;
    end
    if (ce_n && !ce_n_q && vpp_on && !host_oe) begin
      margin_q <= addr[10];
      margin_seen <= margin_seen | addr[10];
    end
    if (pwr_low) margin_q <= 1'b0;
  end
endmodule // eprom_model
`default_nettype wire

// ---- verif/eprom_prog_host_properties.sv ----
// concurrent checks on the pins of the eprom programming host
`timescale 1ns/100ps
`default_nettype none
module eprom_prog_host_props #(
  parameter int INIT_PULSE_CYC   = 50000,
  parameter int MARGIN_PULSE_CYC = 25000
) (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        CMD_GO,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        SRC_REQ,
  input wire logic        SRC_ACK,
  input wire logic [15:0] SRC_ADDR,
  input wire logic [15:0] EP_ADDR,
  input wire logic        EP_CE_N,
  input wire logic        EP_OE_N,
  input wire logic        EP_VPP_ON,
  input wire logic        EP_VCC_PROG,
  input wire logic [7:0]  EP_DQ_OUT,
  input wire logic        EP_DQ_OE
);
  logic [23:0] plen_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // length of the current select pulse under programming voltage
  always @(posedge CORE_CLK) begin
    if (SYS_RST) plen_q <= 24'h000000;
    else plen_q <= (!EP_CE_N && EP_VPP_ON) ? plen_q + 24'h000001 : 24'h000000;
  end
  a_vpp_gate_high: assert property (EP_VPP_ON |-> EP_OE_N) else $error("vpp with gate low");
  a_verify_gate_low: assert property (!EP_OE_N |-> !EP_CE_N && !EP_VPP_ON && !EP_DQ_OE)
    else $error("bad read pins");
  a_idle_standby: assert property (!BUSY && !DONE |-> EP_CE_N && EP_OE_N && !EP_VPP_ON && !EP_DQ_OE)
    else $error("pins not in standby");
  a_pulse_prog_vcc: assert property ($fell(EP_CE_N) && EP_VPP_ON |-> EP_VCC_PROG)
    else $error("pulse at read supply");
  // margin set and reset pulses run with the data pins released, so only a change of drive is wrong
  a_pulse_inputs_hold: assert property (!EP_CE_N && EP_VPP_ON ##1 !EP_CE_N |->
    $stable(EP_ADDR) && $stable(EP_DQ_OUT) && EP_VPP_ON && $stable(EP_DQ_OE)) else $error("pulse inputs moved");
  a_pulse_min_len: assert property ($rose(EP_CE_N) && EP_VPP_ON && EP_DQ_OE |-> plen_q >= MARGIN_PULSE_CYC)
    else $error("pulse too short");
  a_pulse_max_len: assert property (!EP_CE_N && EP_VPP_ON |-> plen_q <= 75 * INIT_PULSE_CYC + 4)
    else $error("pulse too long");
  a_done_one_cycle: assert property (DONE |-> !BUSY ##1 !DONE) else $error("done not a pulse");
  a_go_starts_run: assert property (CMD_GO && !BUSY |=> BUSY) else $error("start ignored");
  a_fetch_held: assert property (SRC_REQ && !SRC_ACK |=> (SRC_REQ && $stable(SRC_ADDR)) || DONE)
    else $error("fetch dropped");
  a_fetch_addr: assert property (SRC_REQ |-> SRC_ADDR == EP_ADDR) else $error("fetch address");
endmodule // eprom_prog_host_props
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the eprom programming host
`timescale 1ns/100ps
`default_nettype none
`include "eprom_prog_consts.vh"
module tb;
  localparam int INIT_CYC = 20;
  logic        CORE_CLK, SYS_RST, CMD_GO, SRC_ACK, PWR_LOW, req_seen;
  logic [1:0]  CMD_OP;
  logic [15:0] CMD_FIRST, CMD_LAST;
  logic [7:0]  SRC_DATA;
  wire         BUSY, DONE, PASS, SRC_REQ, EP_CE_N, EP_OE_N, EP_VPP_ON, EP_VCC_PROG, EP_DQ_OE;
  wire [15:0]  FAIL_ADDR, SRC_ADDR, EP_ADDR;
  wire [7:0]   RD_DATA, EP_DQ_IN, EP_DQ_OUT;
  int          miscompares, n_compared, cycles, acks, t_pwr;
  logic [23:0] rows [0:3];
  eprom_prog_host #(.INIT_PULSE_CYC(INIT_CYC), .MARGIN_PULSE_CYC(10), .SUPPLY_CYC(5)) u_eprom_prog_host (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CMD_GO(CMD_GO), .CMD_OP(CMD_OP), .CMD_FIRST(CMD_FIRST),
    .CMD_LAST(CMD_LAST), .BUSY(BUSY), .DONE(DONE), .PASS(PASS), .FAIL_ADDR(FAIL_ADDR), .RD_DATA(RD_DATA),
    .SRC_REQ(SRC_REQ), .SRC_ADDR(SRC_ADDR), .SRC_DATA(SRC_DATA), .SRC_ACK(SRC_ACK), .PWR_LOW(PWR_LOW),
    .EP_ADDR(EP_ADDR), .EP_CE_N(EP_CE_N), .EP_OE_N(EP_OE_N), .EP_VPP_ON(EP_VPP_ON), .EP_VCC_PROG(EP_VCC_PROG),
    .EP_DQ_IN(EP_DQ_IN), .EP_DQ_OUT(EP_DQ_OUT), .EP_DQ_OE(EP_DQ_OE));
  eprom_model u_eprom_model (.clk(CORE_CLK), .addr(EP_ADDR), .ce_n(EP_CE_N), .oe_n(EP_OE_N), .vpp_on(EP_VPP_ON),
    .pwr_low(PWR_LOW), .host_dq(EP_DQ_OUT), .host_oe(EP_DQ_OE), .dq(EP_DQ_IN));
  function automatic logic [7:0] src_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask
  task automatic test_done;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one command, then wait for its done pulse
  task automatic run(input logic [1:0] op, input logic [15:0] first, input logic [15:0] last);
    int k;
    @(negedge CORE_CLK);
    CMD_OP = op;
    CMD_FIRST = first;
    CMD_LAST = last;
    CMD_GO = 1'b1;
    acks = 0;
    @(negedge CORE_CLK);
    CMD_GO = 1'b0;
    k = 0;
    while (DONE !== 1'b1 && k < 40000) begin
      @(negedge CORE_CLK);
      k++;
    end
    check(DONE === 1'b1, "run did not finish");
  endtask
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  // source responder: acks in the second cycle of a request, so the host must hold it; data changes outside requests
  always @(negedge CORE_CLK) begin
    req_seen <= SRC_REQ && !SRC_ACK;
    SRC_ACK <= SRC_REQ && req_seen && !SRC_ACK;
    SRC_DATA <= SRC_REQ ? src_byte(SRC_ADDR) : ~SRC_DATA;
  end
  // fetch counter and run ceiling
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (SRC_REQ && SRC_ACK) acks <= acks + 1;
    if (cycles == 60000) begin
      miscompares++;
      $display("Error at %0t ns: timeout", $time);
      test_done;
    end
  end
  initial begin
    CMD_GO = 1'b0; CMD_OP = 2'h0; CMD_FIRST = 16'h0000; CMD_LAST = 16'h0000;
    SRC_ACK = 1'b0; SRC_DATA = 8'h00; PWR_LOW = 1'b0; SYS_RST = 1'b1; cycles = 0; req_seen = 1'b0;
    rows[0] = 24'h00003C; rows[1] = 24'hFFFFA5; rows[2] = 24'h040000; rows[3] = 24'h8001FF;
    repeat (16) @(negedge CORE_CLK);
    SYS_RST = 1'b0;
    check(BUSY === 1'b0 && PASS === 1'b0 && EP_CE_N === 1'b1 && EP_VPP_ON === 1'b0, "reset state");
    for (int i = 0; i < 4; i++) begin
      u_eprom_model.mem[rows[i][23:8]] = rows[i][7:0];
      run(`OP_READ, rows[i][23:8], rows[i][23:8]);
      check(RD_DATA === rows[i][7:0] && PASS === 1'b1, "read data");
    end
    // fast method, bytes needing one to three pulses
    for (int a = 16; a < 19; a++) u_eprom_model.need[a] = a - 15;
    run(`OP_FAST, 16'h0010, 16'h0012);
    check(PASS === 1'b1 && acks == 6, "fast run");
    for (int a = 16; a < 19; a++) begin
      check(u_eprom_model.mem[a] === src_byte(a[15:0]), "fast data");
      check(u_eprom_model.cnt[a] == a - 14, "fast pulse count");
      check(u_eprom_model.op_len[a] >= 3 * (a - 15) * INIT_CYC, "short overprogram");
      check(u_eprom_model.op_len[a] <= 3 * (a - 15) * INIT_CYC + 3, "long overprogram");
    end
    // margin method
    u_eprom_model.need[32] = 2;
    run(`OP_MARGIN, 16'h0020, 16'h0021);
    check(PASS === 1'b1 && acks == 4, "margin run");
    check(u_eprom_model.cnt[32] == 2 && u_eprom_model.cnt[33] == 1, "margin pulse count");
    check(u_eprom_model.mem[32] === src_byte(16'h0020), "margin data");
    check(u_eprom_model.margin_seen === 1'b1 && u_eprom_model.margin_q === 1'b0, "margin mode");
    // a cleared bit cannot return to one: both methods give up after the pulse limit
    for (int i = 0; i < 2; i++) begin
      u_eprom_model.mem[48] = 8'h00;
      u_eprom_model.cnt[48] = 0;
      run((i == 0) ? `OP_FAST : `OP_MARGIN, 16'h0030, 16'h0031);
      check(PASS === 1'b0 && FAIL_ADDR === 16'h0030, "byte failure");
      check(u_eprom_model.cnt[48] == 25, "pulse limit");
      check(u_eprom_model.mem[48] === 8'h00, "bit returned to one");
    end
    // supply drop while margin mode is set aborts the run
    // an idle supply dip first clears the margin mode that the failed margin run left set in the part
    PWR_LOW = 1'b1;
    @(negedge CORE_CLK);
    PWR_LOW = 1'b0;
    fork
      run(`OP_MARGIN, 16'h0040, 16'h004F);
      begin
        wait (u_eprom_model.margin_q === 1'b1);
        repeat (300) @(negedge CORE_CLK);
        PWR_LOW = 1'b1;
        t_pwr = cycles;
      end
    join
    check(PASS === 1'b0 && cycles - t_pwr <= 8, "supply drop abort");
    PWR_LOW = 1'b0;
    test_done;
  end
endmodule // tb
bind eprom_prog_host eprom_prog_host_props #(.INIT_PULSE_CYC(INIT_PULSE_CYC), .MARGIN_PULSE_CYC(MARGIN_PULSE_CYC))
  u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CMD_GO(CMD_GO), .BUSY(BUSY), .DONE(DONE), .SRC_REQ(SRC_REQ),
  .SRC_ACK(SRC_ACK), .SRC_ADDR(SRC_ADDR), .EP_ADDR(EP_ADDR), .EP_CE_N(EP_CE_N), .EP_OE_N(EP_OE_N),
  .EP_VPP_ON(EP_VPP_ON), .EP_VCC_PROG(EP_VCC_PROG), .EP_DQ_OUT(EP_DQ_OUT), .EP_DQ_OE(EP_DQ_OE));
`default_nettype wire
